// ---- design/fwc_capture.sv ----
// triggered waveform capture engine with avalon-mm registers
//
// Our own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module fwc_capture #(
    parameter int unsigned P_DIV_STD50  = fwc_pkg::DIV_STD50,
    parameter int unsigned P_DIV_STD60  = fwc_pkg::DIV_STD60,
    parameter int unsigned P_DIV_HI50   = fwc_pkg::DIV_HI50,
    parameter int unsigned P_DIV_HI60   = fwc_pkg::DIV_HI60,
    parameter bit          P_SELECTABLE = 1'b0
) (
    // clock and reset
    input  wire logic                       i_mclk,
    input  wire logic                       i_arst_n,
    // avalon-mm slave
    input  wire logic [7:0]                 i_avs_address,
    input  wire logic                       i_avs_read,
    input  wire logic                       i_avs_write,
    input  wire logic [31:0]                i_avs_writedata,
    output logic      [31:0]                o_avs_readdata,
    output logic                            o_avs_waitrequest,
    // trigger and sampled channels
    input  wire logic                       i_capture_trigger_in,
    input  wire logic [fwc_pkg::MAX_BIN-1:0] i_bin_ch,
    input  wire logic [15:0]                i_ana_raw,
    input  wire logic [15:0]                i_ana_derived,
    output logic      [4:0]                 o_ana_sel,
    output logic                            o_sample_tick,
    // record storage write port
    output logic                            o_st_write,
    output logic      [fwc_pkg::ST_AW-1:0]  o_st_address,
    output logic      [31:0]                o_st_writedata,
    // interrupt
    output logic                            o_irq
);
    import fwc_pkg::*;

    function automatic logic [17:0] ms_to_smp(input logic [15:0] ms, input logic [4:0] f);
        logic [21:0] p;
        p = 22'(ms) * 22'(f);
        return 18'(p / 22'd10);
    endfunction

    logic [1:0]  rst_sync_q;
    logic        rst_n;
    logic [1:0]  trig_sync_q;
    logic        trig_s;

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            trig_sync_q <= 2'h0;
        end else begin
            trig_sync_q <= {trig_sync_q[0], i_capture_trigger_in};
        end
    end
    assign trig_s = trig_sync_q[1];

    // register state
    logic [31:0] rdata_q, rdata_d;
    logic        ack_q, ack_d;
    logic [2:0]  ctrl_q, ctrl_d;
    logic [15:0] pre_ms_q, pre_ms_d, post_ms_q, post_ms_d, max_ms_q, max_ms_d;
    logic [5:0]  ana_cnt_q, ana_cnt_d;
    logic [6:0]  bin_cnt_q, bin_cnt_d;
    logic [31:0] ana_src_q, ana_src_d;
    logic [IRQ_N-1:0] ist_q, ist_d, ien_q, ien_d;
    logic        warn_q, warn_d;
    logic        clear_req;
    logic [IRQ_N-1:0] ev;
    // capture state
    fwc_state_t  st_q, st_d;
    logic [DIV_W-1:0] div_q, div_d, div_lim;
    logic        tick;
    logic [ST_AW-1:0] base_q, base_d, last_base_q, last_base_d, pre_addr_q, pre_addr_d;
    logic [ST_AW:0]   lin_q, lin_d, last_len_q, last_len_d;
    logic [17:0] pre_idx_q, pre_idx_d, seg_q, seg_d;
    logic [17:0] pre_l_q, pre_l_d, max_l_q, max_l_d, post_l_q, post_l_d;
    logic [5:0]  wps_q, wps_d, bw_q, bw_d;
    logic [ST_AW-1:0] baddr_q, baddr_d;
    logic        rearm_q, rearm_d, full_q, full_d;
    logic [15:0] rec_cnt_q, rec_cnt_d;
    logic        we_q, we_d;
    logic [ST_AW-1:0] wa_q, wa_d;
    logic [31:0] wd_q, wd_d;
    // derived settings
    logic        sel40, net60, en;
    logic [4:0]  fac;
    logic [17:0] pre_s, post_s, max_s;
    logic [5:0]  wps;
    logic [25:0] need;
    logic        fits;

    assign en    = ctrl_q[CTRL_EN];
    assign sel40 = P_SELECTABLE & ctrl_q[CTRL_SEL40];
    assign net60 = ctrl_q[CTRL_NET60];
    assign fac   = sel40 ? (net60 ? FAC_HI60 : FAC_HI50) : (net60 ? FAC_STD60 : FAC_STD50);
    assign div_lim = sel40 ? (net60 ? DIV_W'(P_DIV_HI60) : DIV_W'(P_DIV_HI50))
                           : (net60 ? DIV_W'(P_DIV_STD60) : DIV_W'(P_DIV_STD50));
    assign pre_s  = ms_to_smp(pre_ms_q, fac);
    assign post_s = ms_to_smp(post_ms_q, fac);
    assign max_s  = ms_to_smp(max_ms_q, fac);
    assign wps    = BIN_WORDS + ana_cnt_q;
    // worst case size checked before arming so a record with nonzero max and post windows never runs past the end
    assign need = 26'd1 + 26'(pre_s + max_s + post_s) * 26'(wps);
    assign fits = (26'(base_q) + need) <= 26'(MEM_WORDS);
    assign tick = (div_q == div_lim - DIV_W'(1));

    // register file and bus
    always_comb begin
        logic wr;
        wr        = i_avs_write & ack_q;
        ack_d     = (i_avs_read | i_avs_write) & ~ack_q;
        rdata_d   = rdata_q;
        ctrl_d    = ctrl_q;
        pre_ms_d  = pre_ms_q;
        post_ms_d = post_ms_q;
        max_ms_d  = max_ms_q;
        ana_cnt_d = ana_cnt_q;
        bin_cnt_d = bin_cnt_q;
        ana_src_d = ana_src_q;
        ien_d     = ien_q;
        clear_req = 1'b0;
        warn_d    = (32'(pre_ms_q) + 32'(post_ms_q)) > 32'(max_ms_q);
        ist_d     = ist_q;
        if (i_avs_read && !ack_q) begin
            unique case (i_avs_address)
                REG_CTRL:      rdata_d = {29'h0, ctrl_q};
                REG_PRE_MS:    rdata_d = {16'h0, pre_ms_q};
                REG_POST_MS:   rdata_d = {16'h0, post_ms_q};
                REG_MAX_MS:    rdata_d = {16'h0, max_ms_q};
                REG_CHAN:      rdata_d = {17'h0, bin_cnt_q, 2'h0, ana_cnt_q};
                REG_ANA_SRC:   rdata_d = ana_src_q;
                REG_STATUS:    rdata_d = {rec_cnt_q, 12'h0, full_q, warn_q, 2'(st_q)};
                REG_IRQ_STAT:  rdata_d = {28'h0, ist_q};
                REG_IRQ_EN:    rdata_d = {28'h0, ien_q};
                REG_WR_PTR:    rdata_d = {10'h0, base_q};
                REG_LAST_BASE: rdata_d = {10'h0, last_base_q};
                REG_LAST_LEN:  rdata_d = {9'h0, last_len_q};
                default:       rdata_d = 32'h0000_0000;
            endcase
        end
        if (wr) begin
            unique case (i_avs_address)
                REG_CTRL: begin
                    ctrl_d    = i_avs_writedata[2:0];
                    clear_req = i_avs_writedata[CTRL_CLEAR];
                end
                REG_PRE_MS:  pre_ms_d  = i_avs_writedata[15:0];
                REG_POST_MS: post_ms_d = i_avs_writedata[15:0];
                REG_MAX_MS:  max_ms_d  = i_avs_writedata[15:0];
                REG_CHAN: begin
                    // counts above the channel limits are clipped
                    ana_cnt_d = (i_avs_writedata[CHAN_ANA_LSB +: 6] > 6'(MAX_ANA)) ? 6'(MAX_ANA)
                              : i_avs_writedata[CHAN_ANA_LSB +: 6];
                    bin_cnt_d = (i_avs_writedata[CHAN_BIN_LSB +: 7] > 7'(MAX_BIN)) ? 7'(MAX_BIN)
                              : i_avs_writedata[CHAN_BIN_LSB +: 7];
                end
                REG_ANA_SRC: ana_src_d = i_avs_writedata;
                REG_IRQ_CLR: ist_d = ist_q & ~i_avs_writedata[IRQ_N-1:0];
                REG_IRQ_EN:  ien_d = i_avs_writedata[IRQ_N-1:0];
                default: ;
            endcase
        end
        // a new event wins over a clear in the same cycle
        ist_d = ist_d | ev | {(warn_d & ~warn_q), 3'h0};
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q   <= 32'h0000_0000;
            ack_q     <= 1'b0;
            ctrl_q    <= 3'h0;
            pre_ms_q  <= PRE_MS_RST;
            post_ms_q <= POST_MS_RST;
            max_ms_q  <= MAX_MS_RST;
            ana_cnt_q <= ANA_CNT_RST;
            bin_cnt_q <= BIN_CNT_RST;
            ana_src_q <= 32'h0000_0000;
            ist_q     <= 4'h0;
            ien_q     <= 4'h0;
            warn_q    <= 1'b0;
        end else begin
            rdata_q   <= rdata_d;
            ack_q     <= ack_d;
            ctrl_q    <= ctrl_d;
            pre_ms_q  <= pre_ms_d;
            post_ms_q <= post_ms_d;
            max_ms_q  <= max_ms_d;
            ana_cnt_q <= ana_cnt_d;
            bin_cnt_q <= bin_cnt_d;
            ana_src_q <= ana_src_d;
            ist_q     <= ist_d;
            ien_q     <= ien_d;
            warn_q    <= warn_d;
        end
    end

    assign o_avs_readdata    = rdata_q;
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;
    assign o_irq             = |(ist_q & ien_q);

    // capture sequencer and storage writer
    always_comb begin
        logic [ST_AW-1:0] samp_addr;
        logic             start;
        logic [4:0]       ch;
        samp_addr  = baddr_q;
        ch         = 5'(bw_q - BIN_WORDS);
        start      = 1'b0;
        ev         = '0;
        st_d       = st_q;
        div_d      = tick ? DIV_W'(0) : div_q + DIV_W'(1);
        base_d     = base_q;
        last_base_d = last_base_q;
        last_len_d = last_len_q;
        pre_addr_d = pre_addr_q;
        lin_d      = lin_q;
        pre_idx_d  = pre_idx_q;
        seg_d      = seg_q;
        pre_l_d    = pre_l_q;
        max_l_d    = max_l_q;
        post_l_d   = post_l_q;
        wps_d      = wps_q;
        rearm_d    = rearm_q | ~trig_s;
        full_d     = full_q;
        rec_cnt_d  = rec_cnt_q;
        we_d       = 1'b0;
        wa_d       = wa_q;
        wd_d       = wd_q;
        unique case (st_q)
            ST_IDLE: begin
                if (clear_req) begin
                    base_d = '0;
                    full_d = 1'b0;
                end else if (en && fits) begin
                    // window lengths and words per sample are frozen for the whole record
                    st_d       = ST_PRE;
                    pre_l_d    = pre_s;
                    max_l_d    = max_s;
                    post_l_d   = post_s;
                    wps_d      = wps;
                    pre_idx_d  = '0;
                    pre_addr_d = base_q + ST_AW'(1);
                    lin_d      = (ST_AW+1)'(base_q) + (ST_AW+1)'(1) + (ST_AW+1)'(pre_s * 18'(wps));
                end else if (en && !full_q) begin
                    full_d           = 1'b1;
                    ev[IRQ_REFUSE]   = 1'b1;
                end
            end
            ST_PRE: begin
                if (!en || clear_req) begin
                    st_d = ST_IDLE;
                    if (clear_req) begin
                        base_d = '0;
                        full_d = 1'b0;
                    end
                end else if (tick && trig_s && rearm_q) begin
                    st_d            = ST_TRIG;
                    rearm_d         = 1'b0;
                    ev[IRQ_ACCEPT]  = 1'b1;
                    seg_d           = 18'd1;
                    start           = 1'b1;
                    samp_addr       = ST_AW'(lin_q);
                    lin_d           = lin_q + (ST_AW+1)'(wps_q);
                end else if (tick && pre_l_q != '0) begin
                    start      = 1'b1;
                    samp_addr  = pre_addr_q;
                    pre_idx_d  = (pre_idx_q == pre_l_q - 18'd1) ? '0 : pre_idx_q + 18'd1;
                    pre_addr_d = (pre_idx_q == pre_l_q - 18'd1) ? base_q + ST_AW'(1)
                                                                : pre_addr_q + ST_AW'(wps_q);
                end
            end
            ST_TRIG: begin
                if (tick) begin
                    start     = 1'b1;
                    samp_addr = ST_AW'(lin_q);
                    lin_d     = lin_q + (ST_AW+1)'(wps_q);
                    if (!trig_s || seg_q >= max_l_q) begin
                        // this tick's sample already belongs to the post window
                        st_d  = ST_POST;
                        seg_d = 18'd2;
                    end else begin
                        seg_d = seg_q + 18'd1;
                    end
                end
            end
            ST_POST: begin
                if (tick && seg_q > post_l_q) begin
                    // configuration word written at the record head
                    st_d         = ST_IDLE;
                    we_d         = 1'b1;
                    wa_d         = base_q;
                    wd_d         = {sel40, net60, wps_q - BIN_WORDS, 1'b0, bin_cnt_q, 16'(pre_idx_q)};
                    base_d       = ST_AW'(lin_q);
                    last_base_d  = base_q;
                    last_len_d   = lin_q - (ST_AW+1)'(base_q);
                    rec_cnt_d    = rec_cnt_q + 16'h0001;
                    ev[IRQ_DONE] = 1'b1;
                end else if (tick) begin
                    start     = 1'b1;
                    samp_addr = ST_AW'(lin_q);
                    lin_d     = lin_q + (ST_AW+1)'(wps_q);
                    seg_d     = seg_q + 18'd1;
                end
            end
        endcase
        // one sample is a burst: two binary words, then one word per analog channel
        if (start) begin
            bw_d    = 6'h01;
            baddr_d = samp_addr;
        end else if (bw_q != 6'h00 && bw_q < wps_q) begin
            bw_d    = bw_q + 6'h01;
            baddr_d = baddr_q;
        end else begin
            bw_d    = 6'h00;
            baddr_d = baddr_q;
        end
        if (start || bw_q != 6'h00 && bw_q < wps_q) begin
            we_d = 1'b1;
            wa_d = start ? samp_addr : baddr_q + ST_AW'(bw_q);
            if (start) begin
                wd_d = i_bin_ch[31:0] & ~(32'hFFFF_FFFF << bin_cnt_q);
            end else if (bw_q == 6'h01) begin
                wd_d = (bin_cnt_q > 7'd32) ? i_bin_ch[63:32] & ~(32'hFFFF_FFFF << (bin_cnt_q - 7'd32)) : 32'h0;
            end else begin
                wd_d = {16'h0, ana_src_q[ch] ? i_ana_derived : i_ana_raw};
            end
        end
    end

    assign o_ana_sel = 5'(bw_q - BIN_WORDS);

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
            div_q <= '0;
            base_q <= '0;
            last_base_q <= '0;
            last_len_q <= '0;
            pre_addr_q <= '0;
            lin_q <= '0;
            pre_idx_q <= '0;
            seg_q <= '0;
            {pre_l_q, max_l_q, post_l_q} <= '0;
            wps_q <= BIN_WORDS;
            bw_q <= '0;
            baddr_q <= '0;
            rearm_q <= 1'b0;
            full_q <= 1'b0;
            rec_cnt_q <= '0;
            we_q <= 1'b0;
            wa_q <= '0;
            wd_q <= 32'h0000_0000;
        end else begin
            st_q <= st_d;
            div_q <= div_d;
            base_q <= base_d;
            last_base_q <= last_base_d;
            last_len_q <= last_len_d;
            pre_addr_q <= pre_addr_d;
            lin_q <= lin_d;
            pre_idx_q <= pre_idx_d;
            seg_q <= seg_d;
            {pre_l_q, max_l_q, post_l_q} <= {pre_l_d, max_l_d, post_l_d};
            wps_q <= wps_d;
            bw_q <= bw_d;
            baddr_q <= baddr_d;
            rearm_q <= rearm_d;
            full_q <= full_d;
            rec_cnt_q <= rec_cnt_d;
            we_q <= we_d;
            wa_q <= wa_d;
            wd_q <= wd_d;
        end
    end

    assign o_st_write     = we_q;
    assign o_st_address   = wa_q;
    assign o_st_writedata = wd_q;
    assign o_sample_tick  = tick;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!rst_n);

    a_accept_cause: assert property ((st_q == ST_PRE && st_d == ST_TRIG) |-> en && trig_s && rearm_q)
        else $error("capture accepted without enable, trigger or release");
    a_disabled_idle: assert property (!en && st_q == ST_PRE |=> st_q == ST_IDLE)
        else $error("disabled recorder stayed armed");
    a_trig_hold: assert property (st_q == ST_TRIG && tick && trig_s && seg_q < max_l_q |=> st_q == ST_TRIG)
        else $error("triggered section ended while trigger active");
    a_trig_end: assert property (st_q == ST_TRIG && tick && !trig_s |=> st_q == ST_POST)
        else $error("triggered section did not end on trigger release");
    a_retrig_release: assert property ($rose(st_q == ST_TRIG) |-> $past(rearm_q))
        else $error("new record started without trigger release");
    a_post_close: assert property (st_q == ST_POST && tick && seg_q > post_l_q |=> st_q == ST_IDLE && o_st_write && ist_q[IRQ_DONE])
        else $error("record not closed after post window");
    a_pre_wrap: assert property (st_q == ST_PRE && st_d == ST_PRE && tick && pre_l_q != '0 && pre_idx_q == pre_l_q - 18'd1 |=> pre_idx_q == '0 && pre_addr_q == base_q + ST_AW'(1))
        else $error("pre-trigger region did not wrap");
    a_store_bound: assert property (o_st_write |-> 32'(o_st_address) < 32'(MEM_WORDS))
        else $error("storage write beyond capacity");
    a_tick_space: assert property (tick |=> !tick [*8])
        else $error("sample ticks too close");
    a_warn_flag: assert property ($rose(warn_q) |-> ist_q[IRQ_WARN])
        else $error("window warning not flagged");
endmodule

// ---- design/fwc_pkg.sv ----
// constants, register map and types of the fault waveform capture block
package fwc_pkg;
    // clock and sample rates
    localparam int unsigned CLK_HZ      = 100_000_000;
    localparam int unsigned RATE_STD50_HZ = 1000;
    localparam int unsigned RATE_STD60_HZ = 1200;
    localparam int unsigned RATE_HI50_HZ  = 2000;
    localparam int unsigned RATE_HI60_HZ  = 2400;
    localparam int unsigned DIV_STD50   = CLK_HZ / RATE_STD50_HZ;
    localparam int unsigned DIV_STD60   = CLK_HZ / RATE_STD60_HZ;
    localparam int unsigned DIV_HI50    = CLK_HZ / RATE_HI50_HZ;
    localparam int unsigned DIV_HI60    = CLK_HZ / RATE_HI60_HZ;
    localparam int unsigned DIV_W       = 17;
    // samples per 10 ms at each rate, used to turn milliseconds into samples
    localparam logic [4:0]  FAC_STD50   = 5'h0_A;
    localparam logic [4:0]  FAC_STD60   = 5'h0_C;
    localparam logic [4:0]  FAC_HI50    = 5'h1_4;
    localparam logic [4:0]  FAC_HI60    = 5'h1_8;
    // channel limits and storage
    localparam int unsigned MAX_BIN     = 64;
    localparam int unsigned MAX_ANA     = 32;
    localparam logic [5:0]  BIN_WORDS   = 6'h0_2;
    localparam int unsigned MEM_BYTES   = 12 * 1024 * 1024;
    localparam int unsigned MEM_WORDS   = MEM_BYTES / 4;
    localparam int unsigned ST_AW       = 22;
    // register byte offsets
    localparam logic [7:0]  REG_CTRL     = 8'h0_0;
    localparam logic [7:0]  REG_PRE_MS   = 8'h0_4;
    localparam logic [7:0]  REG_POST_MS  = 8'h0_8;
    localparam logic [7:0]  REG_MAX_MS   = 8'h0_C;
    localparam logic [7:0]  REG_CHAN     = 8'h1_0;
    localparam logic [7:0]  REG_ANA_SRC  = 8'h1_4;
    localparam logic [7:0]  REG_STATUS   = 8'h1_8;
    localparam logic [7:0]  REG_IRQ_STAT = 8'h1_C;
    localparam logic [7:0]  REG_IRQ_CLR  = 8'h2_0;
    localparam logic [7:0]  REG_IRQ_EN   = 8'h2_4;
    localparam logic [7:0]  REG_WR_PTR   = 8'h2_8;
    localparam logic [7:0]  REG_LAST_BASE = 8'h2_C;
    localparam logic [7:0]  REG_LAST_LEN = 8'h3_0;
    // control fields
    localparam int unsigned CTRL_EN     = 0;
    localparam int unsigned CTRL_SEL40  = 1;
    localparam int unsigned CTRL_NET60  = 2;
    localparam int unsigned CTRL_CLEAR  = 3;
    // channel register fields
    localparam int unsigned CHAN_ANA_LSB = 0;
    localparam int unsigned CHAN_BIN_LSB = 8;
    // interrupt bits
    localparam int unsigned IRQ_DONE    = 0;
    localparam int unsigned IRQ_REFUSE  = 1;
    localparam int unsigned IRQ_ACCEPT  = 2;
    localparam int unsigned IRQ_WARN    = 3;
    localparam int unsigned IRQ_N       = 4;
    // reset values
    localparam logic [15:0] PRE_MS_RST  = 16'h00_C8;
    localparam logic [15:0] POST_MS_RST = 16'h00_C8;
    localparam logic [15:0] MAX_MS_RST  = 16'h03_E8;
    localparam logic [5:0]  ANA_CNT_RST = 6'h0_0;
    localparam logic [6:0]  BIN_CNT_RST = 7'h0_0;

    typedef enum logic [1:0] {ST_IDLE, ST_PRE, ST_TRIG, ST_POST} fwc_state_t;
endpackage

// ---- tb/fwc_src_model.sv ----
// far-side model: trigger source and analog front end
`timescale 1ns/100ps
module fwc_src_model (
    // clock
    input  wire logic        i_mclk,
    // trigger request from bench, channel select from design
    input  wire logic        i_trig_req,
    input  wire logic [4:0]  i_ana_sel,
    // trigger and analog values
    output logic             o_trig,
    output logic [15:0]      o_raw,
    output logic [15:0]      o_der
);
    // registered so the trigger never moves in the sampling step
    always_ff @(posedge i_mclk) o_trig <= i_trig_req;
    assign o_raw = {11'h000, i_ana_sel};
    assign o_der = ~o_raw;
endmodule

// ---- tb/fault_waveform_capture_bench.sv ----
// self-checking bench for the capture engine
`timescale 1ns/100ps
module fault_waveform_capture_bench;
    import fwc_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        trq = 1'b0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [63:0] bin = 64'h0;
    logic [31:0] rdat, q, st_d;
    logic        wrq, irq, trig, st_w;
    logic [15:0] raw, der;
    logic [4:0]  sel;
    logic        tck;
    int          n;
    localparam int unsigned DIV50 = 100;
    logic [21:0] st_a;
    logic [31:0] mem [int];
    int          seed = 32'h8113_e7bc;
    int          miscompares = 0;
    int          check_count = 0;
    // short dividers keep each record to a few thousand cycles
    fwc_capture #(.P_DIV_STD50(DIV50), .P_DIV_STD60(80), .P_DIV_HI50(50), .P_DIV_HI60(40)) dut_u (
        .i_mclk(clk), .i_arst_n(rst_n), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wd), .o_avs_readdata(rdat), .o_avs_waitrequest(wrq), .i_capture_trigger_in(trig),
        .i_bin_ch(bin), .i_ana_raw(raw), .i_ana_derived(der), .o_ana_sel(sel), .o_sample_tick(tck),
        .o_st_write(st_w), .o_st_address(st_a), .o_st_writedata(st_d), .o_irq(irq));
    fwc_src_model src_u (.i_mclk(clk), .i_trig_req(trq), .i_ana_sel(sel), .o_trig(trig), .o_raw(raw), .o_der(der));
    always #5 clk = ~clk;
    always @(posedge clk) bin <= {$random(seed), $random(seed)};
    always @(posedge clk) if (st_w === 1'b1) mem[st_a] = st_d;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %0t got %h want %h", $time, s, e);
        end
    endtask
    // request held until an edge sees waitrequest low; read data taken at that same edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        {wr, rd, adr, wd} <= {w, !w, a, d};
        @(posedge clk);
        while (wrq !== 1'b0) @(posedge clk);
        q = rdat;
        {wr, rd} <= 2'b00;
        @(posedge clk);
    endtask
    task automatic wirq();
        repeat (4000) if (irq !== 1'b1) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        bus(1'b1, 8'hfc, 32'hffff_ffff);
        bus(1'b0, 8'hfc, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, REG_MAX_MS, 32'h0);
        chk(q, 32'h0000_03e8);
        bus(1'b1, REG_PRE_MS, 32'h4);
        bus(1'b1, REG_POST_MS, 32'h3);
        bus(1'b1, REG_MAX_MS, 32'h5);
        bus(1'b1, REG_CHAN, 32'h0000_4001);
        bus(1'b1, REG_IRQ_EN, 32'h5);
        trq <= 1'b1;
        repeat (600) @(posedge clk);
        bus(1'b0, REG_IRQ_STAT, 32'h0);
        chk(q, 32'h8);
        $display("test disabled done");
        trq <= 1'b0;
        bus(1'b1, REG_ANA_SRC, 32'h1);
        bus(1'b1, REG_CTRL, 32'h1);
        while (tck !== 1'b1) @(posedge clk);
        n = 1;
        @(posedge clk);
        while (tck !== 1'b1) begin
            @(posedge clk);
            n++;
        end
        chk(n, DIV50);
        repeat (1000) @(posedge clk);
        trq <= 1'b1;
        wirq();
        bus(1'b1, REG_IRQ_CLR, 32'h4);
        chk({31'h0, irq}, 32'h0);
        wirq();
        repeat (1500) @(posedge clk);
        bus(1'b0, REG_STATUS, 32'h0);
        chk({16'h0, q[31:16]}, 32'h1);
        bus(1'b0, REG_LAST_LEN, 32'h0);
        chk(q, 32'h0000_0025);
        bus(1'b0, REG_LAST_BASE, 32'h0);
        chk(mem[q] & 32'hbf7f_0000, 32'h0140_0000);
        chk(mem[q + 3], 32'h0000_ffff);
        $display("test long record done");
        bus(1'b1, REG_IRQ_EN, 32'h0);
        bus(1'b1, REG_IRQ_CLR, 32'hf);
        trq <= 1'b0;
        repeat (800) @(posedge clk);
        trq <= 1'b1;
        repeat (150 + ($random(seed) & 255)) @(posedge clk);
        trq <= 1'b0;
        repeat (1500) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, REG_IRQ_EN, 32'h1);
        wirq();
        bus(1'b0, REG_LAST_LEN, 32'h0);
        chk({31'h0, q >= 32'h19 && q <= 32'h25}, 32'h1);
        bus(1'b1, REG_IRQ_CLR, 32'h1);
        chk({31'h0, irq}, 32'h0);
        $display("test short record done");
        bus(1'b1, REG_CTRL, 32'h0);
        bus(1'b1, REG_MAX_MS, 32'h7);
        bus(1'b0, REG_STATUS, 32'h0);
        chk(q & 32'h7, 32'h0);
        bus(1'b1, REG_MAX_MS, 32'h6);
        bus(1'b1, REG_CTRL, 32'h1);
        repeat (5) @(posedge clk);
        bus(1'b0, REG_STATUS, 32'h0);
        chk({31'h0, q[2]}, 32'h1);
        bus(1'b0, REG_IRQ_STAT, 32'h0);
        chk({31'h0, q[IRQ_WARN]}, 32'h1);
        $display("test warning done");
        end_sim();
    end
    initial begin
        repeat (30000) @(posedge clk);
        miscompares++;
        end_sim();
    end
endmodule
